// File: irq_route_pkg.sv
// Function
// - Sharing is limited to IRQ 0 through 23.
// - Track assert state per source ID.
// - One initiator per IRQ 24 through 119.
// - Multi-cause initiators aggregate or get unique IRQs.
// - Multi-function initiators aggregate or get unique IRQs.
// - Only level-triggered IRQs may be shared.
// - Legacy mode routes PCI lines to 3-7,9-12,14,15.
// - Legacy lines 0, 2, 8 are dedicated.
// - Advanced 0 cascade, 2 timer, 8 RTC.
// - Advanced mode maps PCI A-H to 16-23.
// - Advanced polarity low on 16-23, else high.
// - IRQ 24-119 individually level or edge.
// - Avoid serial IRQs already used by PCI/SYSTEM_CONTROL_IRQ/watchdog.
// - GPIO pin mode keeps internal PCI A alive.
// - ACPI devices direct; PCI devices via INT pin.
// - Advanced 16-19 accept pin, serial link, forwarded.
// - Advanced 20-23 internal sources only; the router also lets sideband messages assert them.
// - Accept forwarded INT A-D assert/deassert messages.
// - Active-low sources inverted before legacy controllers.
// Constants shared by the router, its initiator end and the link.
// Assumes both ends run on one clock.
package irq_route_pkg;
  localparam int NUM_IRQ = 120;
  localparam int NUM_SHR = 24;
  localparam int NUM_SRC = 16;
  localparam int SRC_W   = 4;
  localparam int IRQ_W   = 7;
  localparam int NUM_PCI = 8;
  localparam int NUM_LEG = 16;
  localparam int SYS_W   = 5;
  localparam int RT_W    = 4;
  // Legal legacy lines per kind of source.
  localparam logic [15:0] LEG_PCI_OK = 16'hDEF8;
  localparam logic [15:0] SER_OK     = 16'hDEFA;
  localparam logic [15:0] LEG_MSG_OK = 16'hFEFA;
  localparam logic [NUM_IRQ-1:0] ADV_LOW = 120'hFF0000;
  localparam int IRQ_TMR_LEG  = 0;
  localparam int IRQ_CASC_LEG = 2;
  localparam int IRQ_CASC_ADV = 0;
  localparam int IRQ_TMR_ADV  = 2;
  localparam int IRQ_RTC      = 8;
  localparam int IRQ_ETMR2    = 11;
  localparam int IRQ_ETMR3    = 12;
  localparam int IRQ_PCI_ADV  = 16;
  localparam int IRQ_INT_ADV  = 20;
  localparam int SYS_LEG_LO   = 9;
  localparam int SYS_LEG_HI   = 11;
  // Register map of the initiator end.
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_ROUTE = 8'h04;
  localparam logic [7:0] OFF_MSG   = 8'h08;
  localparam logic [7:0] OFF_STAT  = 8'h0C;
  localparam logic [7:0] OFF_TRIG0 = 8'h10;
  localparam int NUM_TRIG = 3;
  localparam int CTRL_LEGACY = 0;
  localparam int CTRL_GPIO   = 1;
  localparam int CTRL_ETMR0  = 2;
  localparam int CTRL_ETMR1  = 3;
  localparam int CTRL_PIN    = 4;
  localparam int CTRL_SCI    = 8;
  localparam int CTRL_WD     = 16;
  localparam int MSG_IRQ     = 0;
  localparam int MSG_SRC     = 8;
  localparam int MSG_ASSERT  = 12;
  localparam int MSG_CPU     = 13;
  localparam logic [31:0] CTRL_RST  = 32'h00000001;
  localparam logic [31:0] ROUTE_RST = 32'h00000000;
  localparam logic [31:0] TRIG_RST  = 32'hFFFFFFFF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : irq_route_pkg

// File: irq_link_if.sv
// Link between the interrupt initiators and the IRQ router.
// Assumes both ends share sys_clk; the pin needs an external pull-up.
`timescale 1ns/1ns
interface irq_link_if;
  import irq_route_pkg::*;
  // Sideband assert/deassert messages.
  logic                      msgValid;
  logic                      msgReady;
  logic                      msgAssert;
  logic                      msgCpu;
  logic [SRC_W-1:0]          msgSrc;
  logic [IRQ_W-1:0]          msgIrq;
  logic                      msgRefused;
  // Open-drain PCI interrupt A pin.
  logic                      pinOut;
  logic                      pinOe;
  logic                      pinIn;
  // Decoded serial link levels.
  logic [NUM_LEG-1:0]        serial_irq_link;
  logic [3:0]                serPirqN;
  // Routing configuration.
  logic                      legacyMode;
  logic                      pinIsGpio;
  logic                      selEtmr0;
  logic                      selEtmr1;
  logic [SYS_W-1:0]          sciIrqNum;
  logic [SYS_W-1:0]          wdIrqNum;
  logic [RT_W*NUM_PCI-1:0]   route;
  logic [NUM_IRQ-1:NUM_SHR]  trigLevel;

  // The pull-up holds the wire high unless someone drives it low.
  assign pinIn = (pinOe && !pinOut) ? 1'b0 : 1'b1;

  modport router (
    input  msgValid, msgAssert, msgCpu, msgSrc, msgIrq, pinIn,
    input  serial_irq_link, serPirqN, legacyMode, pinIsGpio, selEtmr0,
    input  selEtmr1, sciIrqNum, wdIrqNum, route, trigLevel,
    output msgReady, msgRefused
  );
  modport initiator (
    output msgValid, msgAssert, msgCpu, msgSrc, msgIrq, pinOut,
    output pinOe, serial_irq_link, serPirqN, legacyMode, pinIsGpio,
    output selEtmr0, selEtmr1, sciIrqNum, wdIrqNum, route, trigLevel,
    input  msgReady, msgRefused, pinIn
  );
endinterface : irq_link_if

// File: irq_share_tracker.sv
// Per-source assert state of one shareable IRQ.
// Assumes set and clear name the source that sent the message.
`timescale 1ns/1ns
module irq_share_tracker #(
  parameter int NSRC = 16
) (
  // Clock and reset.
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  // Message strobes.
  input  wire logic                    setEn,
  input  wire logic                    clrEn,
  input  wire logic [$clog2(NSRC)-1:0] src,
  // Wired-OR of all sources.
  output logic                         active
);
  logic [NSRC-1:0] state_reg;

  // Refused at elaboration, since one source cannot be shared.
  if (NSRC < 2) begin : g_bad_nsrc
    $error("NSRC must be at least 2");
  end

  // Only level semantics are kept, so shared sources wire-OR safely.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else if (setEn) begin
      state_reg[src] <= 1'b1;
    end else if (clrEn) begin
      state_reg[src] <= 1'b0;
    end
  end

  assign active = |state_reg;
endmodule : irq_share_tracker

// File: irq_router.sv
// IRQ router: maps PCI lines, serial link, messages and internal
// sources onto legacy or advanced controller inputs.
// Assumes configuration on the link is stable while interrupts flow.
`timescale 1ns/1ns
module irq_router (
  // Clock and reset.
  input  wire logic                              sys_clk,
  input  wire logic                              reset,
  // Link to the initiators.
  irq_link_if.router                             link,
  // Internal sources.
  input  wire logic                              timer0,
  input  wire logic [3:0]                        etmr,
  input  wire logic                              rtcIrqN,
  input  wire logic                              sciIrq,
  input  wire logic                              wdIrq,
  input  wire logic [irq_route_pkg::NUM_PCI-1:0] intPciN,
  input  wire logic                              acpiIrq,
  input  wire logic                              acpiPciMode,
  input  wire logic [1:0]                        acpiPin,
  input  wire logic [irq_route_pkg::IRQ_W-1:0]   acpiIrqNum,
  // Cascade outputs of the legacy controllers.
  input  wire logic                              slaveIntr,
  input  wire logic                              masterIntr,
  // Controller inputs.
  output logic [irq_route_pkg::NUM_LEG-1:0]      legacyIrq,
  output logic [irq_route_pkg::NUM_IRQ-1:0]      advIrq
);
  import irq_route_pkg::*;

  logic                     pinMeta_reg;
  logic                     pinSync_reg;
  logic [3:0]               cpuInt_reg;
  logic                     refused_reg;
  logic [NUM_SHR-1:0]       shrAct;
  logic [NUM_IRQ-1:NUM_SHR] dedState_reg;
  logic [NUM_IRQ-1:NUM_SHR] dedPulse_reg;
  logic [SRC_W-1:0]         owner_reg [NUM_IRQ-1:NUM_SHR];
  logic [NUM_PCI-1:0]       pciAct;
  logic [NUM_LEG-1:0]       legNext;
  logic [NUM_IRQ-1:0]       actNext;
  logic                     msgOk;
  logic                     take;
  logic                     dedHit;
  logic                     dedClash;
  logic                     acpiDirect;

  function automatic logic sysOk(input logic leg,
                                 input logic [SYS_W-1:0] n);
    logic inLeg;
    inLeg = (n >= SYS_W'(SYS_LEG_LO)) && (n <= SYS_W'(SYS_LEG_HI));
    if (leg) begin
      return inLeg;
    end
    return inLeg || (n >= SYS_W'(IRQ_INT_ADV) &&
                     n < SYS_W'(NUM_SHR));
  endfunction : sysOk

  // The message channel never stalls, so initiators need no queue.
  assign link.msgReady = 1'b1;
  assign take          = link.msgValid;
  assign link.msgRefused = refused_reg;

  // A dedicated line already owned by another source refuses it.
  assign dedHit = !link.msgCpu && link.msgIrq >= IRQ_W'(NUM_SHR) &&
                  link.msgIrq < IRQ_W'(NUM_IRQ);
  assign dedClash = dedHit && dedState_reg[link.msgIrq] &&
                    owner_reg[link.msgIrq] != link.msgSrc;

  always_comb begin
    msgOk = 1'b0;
    if (link.msgCpu) begin
      msgOk = 1'b1;
    end else if (link.legacyMode) begin
      msgOk = link.msgIrq < IRQ_W'(NUM_LEG) &&
              LEG_MSG_OK[link.msgIrq[3:0]];
    end else begin
      msgOk = link.msgIrq < IRQ_W'(NUM_IRQ) &&
              link.msgIrq != IRQ_W'(IRQ_CASC_ADV) &&
              link.msgIrq != IRQ_W'(IRQ_TMR_ADV) &&
              link.msgIrq != IRQ_W'(IRQ_RTC) && !dedClash;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= take && !msgOk;
    end
  end

  // The pin comes from the board and is synchronised first.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pinMeta_reg <= 1'b1;
      pinSync_reg <= 1'b1;
    end else begin
      pinMeta_reg <= link.pinIn;
      pinSync_reg <= pinMeta_reg;
    end
  end

  // Forwarded INT A-D state from the processor complex.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cpuInt_reg <= '0;
    end else if (take && link.msgCpu) begin
      cpuInt_reg[link.msgIrq[1:0]] <= link.msgAssert;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_SHR; i++) begin : g_shr
      logic hit;
      assign hit = take && msgOk && !link.msgCpu &&
                   link.msgIrq == IRQ_W'(i);
      irq_share_tracker #(.NSRC(NUM_SRC)) u_trk (
        .sys_clk (sys_clk),
        .reset   (reset),
        .setEn   (hit && link.msgAssert),
        .clrEn   (hit && !link.msgAssert),
        .src     (link.msgSrc),
        .active  (shrAct[i])
      );
    end
    for (i = NUM_SHR; i < NUM_IRQ; i++) begin : g_ded
      logic hit;
      assign hit = take && msgOk && dedHit &&
                   link.msgIrq == IRQ_W'(i);
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          dedState_reg[i] <= 1'b0;
          dedPulse_reg[i] <= 1'b0;
          owner_reg[i]    <= '0;
        end else begin
          dedPulse_reg[i] <= hit && link.msgAssert &&
                             !dedState_reg[i];
          if (hit) begin
            dedState_reg[i] <= link.msgAssert;
            owner_reg[i]    <= link.msgSrc;
          end
        end
      end
    end
  endgenerate

  // Internal PCI lines in active-high sense.
  always_comb begin
    pciAct = ~intPciN;
    if (acpiPciMode && acpiIrq) begin
      pciAct[acpiPin] = 1'b1;
    end
    pciAct[0] = pciAct[0] ||
                (!pinSync_reg && !link.pinIsGpio);
    pciAct[3:0] = pciAct[3:0] | ~link.serPirqN | cpuInt_reg;
  end

  assign acpiDirect = acpiIrq && !acpiPciMode;

  always_comb begin
    legNext = '0;
    for (int n = 0; n < NUM_LEG; n++) begin
      legNext[n] = shrAct[n] || (link.serial_irq_link[n] && SER_OK[n]) ||
                   (acpiDirect && acpiIrqNum == IRQ_W'(n) &&
                    LEG_MSG_OK[n]);
    end
    for (int k = 0; k < NUM_PCI; k++) begin
      if (LEG_PCI_OK[link.route[k*RT_W +: RT_W]]) begin
        legNext[link.route[k*RT_W +: RT_W]] = 1'b1 &&
          (pciAct[k] || legNext[link.route[k*RT_W +: RT_W]]);
      end
    end
    if (sysOk(1'b1, link.sciIrqNum) && sciIrq) begin
      legNext[link.sciIrqNum[3:0]] = 1'b1;
    end
    if (sysOk(1'b1, link.wdIrqNum) && wdIrq) begin
      legNext[link.wdIrqNum[3:0]] = 1'b1;
    end
    legNext[IRQ_ETMR2]    = legNext[IRQ_ETMR2] || etmr[2];
    legNext[IRQ_ETMR3]    = legNext[IRQ_ETMR3] || etmr[3];
    legNext[IRQ_TMR_LEG]  = link.selEtmr0 ? etmr[0] : timer0;
    legNext[IRQ_CASC_LEG] = slaveIntr;
    legNext[IRQ_RTC]      = link.selEtmr1 ? etmr[1] : !rtcIrqN;
    if (!link.legacyMode) begin
      legNext = '0;
    end
  end

  always_comb begin
    actNext = '0;
    for (int n = 0; n < NUM_LEG; n++) begin
      actNext[n] = shrAct[n] || (link.serial_irq_link[n] && SER_OK[n]);
    end
    for (int n = 0; n < NUM_PCI; n++) begin
      actNext[IRQ_PCI_ADV+n] = shrAct[IRQ_PCI_ADV+n] ||
                               pciAct[n];
    end
    for (int n = NUM_SHR; n < NUM_IRQ; n++) begin
      actNext[n] = link.trigLevel[n] ? dedState_reg[n]
                                     : dedPulse_reg[n];
    end
    if (acpiDirect && acpiIrqNum < IRQ_W'(NUM_IRQ)) begin
      actNext[acpiIrqNum] = 1'b1;
    end
    if (sysOk(1'b0, link.sciIrqNum) && sciIrq) begin
      actNext[link.sciIrqNum] = 1'b1;
    end
    if (sysOk(1'b0, link.wdIrqNum) && wdIrq) begin
      actNext[link.wdIrqNum] = 1'b1;
    end
    actNext[IRQ_ETMR2]    = actNext[IRQ_ETMR2] || etmr[2];
    actNext[IRQ_ETMR3]    = actNext[IRQ_ETMR3] || etmr[3];
    actNext[IRQ_CASC_ADV] = masterIntr;
    actNext[IRQ_TMR_ADV]  = link.selEtmr0 ? etmr[0] : timer0;
    actNext[IRQ_RTC]      = link.selEtmr1 ? etmr[1] : !rtcIrqN;
    if (link.legacyMode) begin
      actNext = '0;
    end
  end

  // Outputs are registered so controllers see glitch-free levels.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      legacyIrq <= '0;
      advIrq    <= ADV_LOW;
    end else begin
      legacyIrq <= legNext;
      advIrq    <= actNext ^ ADV_LOW;
    end
  end
endmodule : irq_router

// File: irq_initiator.sv
// Initiator end: AXI4-Lite registers that configure routing, send
// sideband messages and drive the open-drain PCI interrupt A pin.
// Assumes an AXI4-Lite master on sys_clk and a decoded serial link.
`timescale 1ns/1ns
module irq_initiator (
  // Clock and reset.
  input  wire logic                                sys_clk,
  input  wire logic                                reset,
  // Link to the router.
  irq_link_if.initiator                            link,
  // AXI4-Lite slave.
  input  wire logic [irq_route_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                                awvalid,
  output logic                                     awready,
  input  wire logic [31:0]                         wdata,
  input  wire logic [3:0]                          wstrb,
  input  wire logic                                wvalid,
  output logic                                     wready,
  output logic [1:0]                               bresp,
  output logic                                     bvalid,
  input  wire logic                                bready,
  input  wire logic [irq_route_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                                arvalid,
  output logic                                     arready,
  output logic [31:0]                              rdata,
  output logic [1:0]                               rresp,
  output logic                                     rvalid,
  input  wire logic                                rready,
  // Decoded serial link levels.
  input  wire logic [irq_route_pkg::NUM_LEG-1:0]   serIrqIn,
  input  wire logic [3:0]                          serPirqNIn
);
  import irq_route_pkg::*;

  logic [31:0] ctrl_reg;
  logic [31:0] route_reg;
  logic [31:0] msg_reg;
  logic [31:0] trig_reg [NUM_TRIG];
  logic        msgBusy_reg;
  logic [7:0]  refCnt_reg;
  logic        wrGo;
  logic [31:0] rdNext;
  logic        rdHit;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Address and data are taken together, one write at a time.
  assign wrGo    = awvalid && wvalid && !bvalid;
  assign awready = wrGo;
  assign wready  = wrGo;
  assign arready = !rvalid;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg  <= CTRL_RST;
      route_reg <= ROUTE_RST;
      for (int t = 0; t < NUM_TRIG; t++) begin
        trig_reg[t] <= TRIG_RST;
      end
    end else if (wrGo) begin
      if (awaddr == OFF_CTRL) begin
        ctrl_reg <= merge(ctrl_reg, wdata, wstrb);
      end
      if (awaddr == OFF_ROUTE) begin
        route_reg <= merge(route_reg, wdata, wstrb);
      end
      for (int t = 0; t < NUM_TRIG; t++) begin
        if (awaddr == OFF_TRIG0 + ADDR_W'(4 * t)) begin
          trig_reg[t] <= merge(trig_reg[t], wdata, wstrb);
        end
      end
    end
  end

  // A message write while one is pending is dropped; software polls
  // the busy bit, which keeps the link to one message in flight.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      msg_reg     <= '0;
      msgBusy_reg <= 1'b0;
    end else if (wrGo && awaddr == OFF_MSG && !msgBusy_reg) begin
      msg_reg     <= merge(msg_reg, wdata, wstrb);
      msgBusy_reg <= 1'b1;
    end else if (msgBusy_reg && link.msgReady) begin
      msgBusy_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      refCnt_reg <= '0;
    end else if (link.msgRefused) begin
      refCnt_reg <= refCnt_reg + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wrGo) begin
      bvalid <= 1'b1;
      bresp  <= (awaddr == OFF_STAT || awaddr[1:0] != 2'h0 ||
                 awaddr > OFF_TRIG0 + ADDR_W'(4 * (NUM_TRIG - 1)))
                ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_comb begin
    rdNext = '0;
    rdHit  = 1'b1;
    case (araddr)
      OFF_CTRL:  rdNext = ctrl_reg;
      OFF_ROUTE: rdNext = route_reg;
      OFF_MSG:   rdNext = msg_reg;
      OFF_STAT:  rdNext = {16'h0000, refCnt_reg, 7'h00, msgBusy_reg};
      default: begin
        rdHit = 1'b0;
        for (int t = 0; t < NUM_TRIG; t++) begin
          if (araddr == OFF_TRIG0 + ADDR_W'(4 * t)) begin
            rdNext = trig_reg[t];
            rdHit  = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= rdNext;
      rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // One source ID per message keeps aggregation in software's hands.
  assign link.msgValid  = msgBusy_reg;
  assign link.msgIrq    = msg_reg[MSG_IRQ +: IRQ_W];
  assign link.msgSrc    = msg_reg[MSG_SRC +: SRC_W];
  assign link.msgAssert = msg_reg[MSG_ASSERT];
  assign link.msgCpu    = msg_reg[MSG_CPU];
  // Open drain: drive low only, release for high.
  assign link.pinOut    = 1'b0;
  assign link.pinOe     = ctrl_reg[CTRL_PIN] && !ctrl_reg[CTRL_GPIO];
  assign link.serial_irq_link    = serIrqIn;
  assign link.serPirqN  = serPirqNIn;
  assign link.legacyMode = ctrl_reg[CTRL_LEGACY];
  assign link.pinIsGpio = ctrl_reg[CTRL_GPIO];
  assign link.selEtmr0  = ctrl_reg[CTRL_ETMR0];
  assign link.selEtmr1  = ctrl_reg[CTRL_ETMR1];
  assign link.sciIrqNum = ctrl_reg[CTRL_SCI +: SYS_W];
  assign link.wdIrqNum  = ctrl_reg[CTRL_WD +: SYS_W];
  assign link.route     = route_reg;
  // Level at reset so board-shared lines are safe to share.
  assign link.trigLevel = {trig_reg[2], trig_reg[1], trig_reg[0]};
endmodule : irq_initiator

// File: irq_route_chk.sv
// Assertions on the interrupt link and the router's controller inputs.
// Assumes one clock domain; the bench places it beside the link.
`timescale 1ns/1ns
module irq_route_chk (
  // Clock and reset.
  input wire logic         sys_clk,
  input wire logic         reset,
  // Link signals.
  input wire logic         msgValid,
  input wire logic         msgCpu,
  input wire logic [6:0]   msgIrq,
  input wire logic         msgRefused,
  input wire logic         legacyMode,
  input wire logic         selEtmr0,
  // Router sources and outputs.
  input wire logic         timer0,
  input wire logic [3:0]   etmr,
  input wire logic         slaveIntr,
  input wire logic         masterIntr,
  input wire logic [7:0]   intPciN,
  input wire logic [15:0]  legacyIrq,
  input wire logic [119:0] advIrq
);
  import irq_route_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic tmr;
  assign tmr = selEtmr0 ? etmr[0] : timer0;
  // Two cycles of a steady mode cover the output register after a switch.
  chk_leg_above:
    assert property (msgValid && !msgCpu && legacyMode && msgIrq > 7'h0F
      |=> msgRefused) else $error("legacy message above 15 kept");
  chk_fixed_lines:
    assert property (msgValid && !msgCpu && msgIrq inside {7'h00, 7'h02,
      7'h08} |=> msgRefused) else $error("message to fixed line kept");
  chk_adv_range:
    assert property (msgValid && !msgCpu && !legacyMode && msgIrq > 7'h77
      |=> msgRefused) else $error("message above 119 kept");
  chk_casc_legacy:
    assert property (legacyMode [*2] |-> legacyIrq[2] == $past(slaveIntr))
      else $error("legacy cascade line wrong");
  chk_tmr_legacy:
    assert property (legacyMode [*2] |-> legacyIrq[0] == $past(tmr))
      else $error("legacy timer line wrong");
  chk_casc_adv:
    assert property (!legacyMode [*2] |-> advIrq[0] == $past(masterIntr))
      else $error("advanced cascade line wrong");
  chk_tmr_adv:
    assert property (!legacyMode [*2] |-> advIrq[2] == $past(tmr))
      else $error("advanced timer line wrong");
  chk_pci_adv:
    assert property (!legacyMode [*2] |->
      (advIrq[23:16] & ~$past(intPciN)) == 8'h00) else $error("PCI lost");
  chk_adv_quiet:
    assert property (legacyMode [*2] |-> advIrq == ADV_LOW)
      else $error("advanced inputs active in legacy mode");
  cover property (msgValid && msgIrq == 7'h18);
  cover property (msgRefused);
  cover property (!legacyMode && !advIrq[16]);
endmodule : irq_route_chk

// File: testbench.sv
// Bench joining both link ends, with an AXI4-Lite master and sources.
// Assumes routing state reaches the router only through the link.
`timescale 1ns/1ns
module testbench;
  import irq_route_pkg::*;
  // Control, route, sources, serial, internal device, expected outputs.
  typedef struct packed {
    logic [31:0] c, r;
    logic [21:0] i;
    logic [15:0] s;
    logic [10:0] a;
    logic [15:0] l;
    logic [23:0] v;
  } row_t;
  row_t rows [6] = '{
    '{32'h000A0901, 32'h25, 22'h3FF241, 16'h0, 11'h0, 16'h0325, 24'hFF0000},
    '{32'hD, 32'h0, 22'h3FFC26, 16'h0, 11'h0, 16'h0101, 24'hFF0000},
    '{32'h000B1406, 32'h0, 22'h3DF9DA, 16'h0, 11'h0, 16'h0, 24'h6E1905},
    '{32'h0, 32'h0, 22'h37FC20, 16'h0020, 11'h40D, 16'h0, 24'hFD2020},
    '{32'h1, 32'h0, 22'h3FFC20, 16'h2014, 11'h0, 16'h0010, 24'hFF0000},
    '{32'h0, 32'h0, 22'h3FFC20, 16'h0, 11'h700, 16'h0, 24'hFB0000}};
  logic         sys_clk = 1'h0, reset = 1'h1, timer0, rtcIrqN, sciIrq;
  logic         wdIrq, slaveIntr, masterIntr, acpiIrq, acpiPciMode;
  logic [3:0]   etmr, serPirqNIn, wstrb = 4'hF;
  logic [7:0]   intPciN, awaddr = 8'h0, araddr = 8'h0;
  logic [1:0]   acpiPin, bresp, rresp;
  logic [6:0]   acpiIrqNum;
  logic [15:0]  serIrqIn, legacyIrq;
  logic [119:0] advIrq;
  logic [31:0]  wdata = 32'h0, rdata;
  logic         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic         arvalid = 1'h0, rready = 1'h0;
  logic         awready, wready, bvalid, arready, rvalid;
  int           nMismatch = 0, checked = 0, cyc = 0, n;
  irq_link_if lk ();
  irq_router i_irq_router (.sys_clk, .reset, .link(lk), .timer0, .etmr,
    .rtcIrqN, .sciIrq, .wdIrq, .intPciN, .acpiIrq, .acpiPciMode, .acpiPin,
    .acpiIrqNum, .slaveIntr, .masterIntr, .legacyIrq, .advIrq);
  irq_initiator i_irq_initiator (.sys_clk, .reset, .link(lk), .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .serIrqIn, .serPirqNIn);
  irq_route_chk i_irq_route_chk (.sys_clk, .reset, .msgValid(lk.msgValid),
    .msgCpu(lk.msgCpu), .msgIrq(lk.msgIrq), .msgRefused(lk.msgRefused),
    .legacyMode(lk.legacyMode), .selEtmr0(lk.selEtmr0), .timer0, .etmr,
    .slaveIntr, .masterIntr, .intPciN, .legacyIrq, .advIrq);
  always #5 sys_clk = ~sys_clk;
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // A stuck handshake would otherwise hang the run silently.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      nMismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [119:0] s, input logic [119:0] e);
    checked++;
    if (s !== e) begin
      nMismatch++;
      $display("[FAIL] %0t: got %0h want %0h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = RESP_OKAY);
    @(posedge sys_clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do @(posedge sys_clk); while (!(awready && wready));
    {awvalid, wvalid} <= 2'h0;
    do @(posedge sys_clk); while (!bvalid);
    bready <= 1'h0;
    chk(bresp, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = RESP_OKAY);
    @(posedge sys_clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge sys_clk); while (!rvalid);
    rready <= 1'h0;
    chk({rresp, rdata}, {e, d});
  endtask : rd
  task automatic msg(input logic [6:0] q, input logic [3:0] s, input logic x,
                     input logic cp);
    wr(OFF_MSG, {18'h0, cp, x, s, 1'h0, q});
    repeat (4) @(posedge sys_clk);
  endtask : msg
  initial begin
    {serPirqNIn, intPciN, slaveIntr, masterIntr, wdIrq, sciIrq, rtcIrqN, etmr,
     timer0} = 22'h3FFC20;
    {acpiIrq, acpiPciMode, acpiPin, acpiIrqNum, serIrqIn} = 27'h0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'h0;
    foreach (rows[k]) begin
      wr(OFF_CTRL, rows[k].c);
      wr(OFF_ROUTE, rows[k].r);
      {serPirqNIn, intPciN, slaveIntr, masterIntr, wdIrq, sciIrq, rtcIrqN,
       etmr, timer0} <= rows[k].i;
      {acpiIrq, acpiPciMode, acpiPin, acpiIrqNum} <= rows[k].a;
      serIrqIn <= rows[k].s;
      repeat (5) @(posedge sys_clk);
      chk(legacyIrq, rows[k].l);
      chk(advIrq, {96'h0, rows[k].v});
    end
    {acpiIrq, reset} <= 2'h1;
    repeat (2) @(posedge sys_clk);
    chk(legacyIrq, 16'h0);
    chk(advIrq, ADV_LOW);
    reset <= 1'h0;
    rd(OFF_CTRL, CTRL_RST);
    rd(OFF_TRIG0 + 8'h08, TRIG_RST);
    wr(OFF_STAT, 32'h0, RESP_SLVERR);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    msg(7'h03, 4'h1, 1'h1, 1'h0);
    msg(7'h03, 4'h2, 1'h1, 1'h0);
    msg(7'h03, 4'h1, 1'h0, 1'h0);
    chk(legacyIrq[3], 1'h1);
    msg(7'h03, 4'h2, 1'h0, 1'h0);
    chk(legacyIrq[3], 1'h0);
    msg(7'h10, 4'h1, 1'h1, 1'h0);
    msg(7'h08, 4'h1, 1'h1, 1'h0);
    rd(OFF_STAT, 32'h200);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_TRIG0, 32'h0);
    wr(OFF_MSG, 32'h1118);
    n = 0;
    repeat (8) begin
      @(posedge sys_clk);
      n += advIrq[24];
    end
    chk(n, 1);
    msg(7'h38, 4'h1, 1'h1, 1'h0);
    msg(7'h38, 4'h2, 1'h1, 1'h0);
    msg(7'h02, 4'h3, 1'h1, 1'h0);
    chk(advIrq[56], 1'h1);
    rd(OFF_STAT, 32'h400);
    wr(OFF_CTRL, 32'h10);
    repeat (5) @(posedge sys_clk);
    chk(advIrq[23:16], 8'hFE);
    wr(OFF_CTRL, 32'h0);
    msg(7'h01, 4'h4, 1'h1, 1'h1);
    chk(advIrq[23:16], 8'hFD);
    final_report();
  end
endmodule : testbench
